// File: core/htr_sensor.sv
// Sensor end: serial slave, conversion timing and result registers
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
// How it works
// - Host waits 15 ms after power-up.
// - Pointer write to temperature or humidity triggers a conversion.
// - One read burst returns both results.
// - Host waits one second between reads.
// - Temperature or humidity pointer write during conversion restarts the conversion.
// - Read during conversion gets a NACK.
// - Host opens with address and write bit.
// - Pointer zero acknowledged, then advances to humidity.
// - Host waits both conversion times before reading.
// - Host reads four bytes, NACKs last.
// - Two result LSBs always read zero.
// - Host scales raw values to degrees, percent.
// - Conversion time follows selected resolution.
// - Mode bit converts temperature then humidity.
// - Configuration selects temperature and humidity resolutions.
module htr_sensor #(
	parameter int TMP14_CYC = htr_pkg::cyc_of_us(htr_pkg::T_TMP14_US),
	parameter int TMP11_CYC = htr_pkg::cyc_of_us(htr_pkg::T_TMP11_US),
	parameter int HUM14_CYC = htr_pkg::cyc_of_us(htr_pkg::T_HUM14_US),
	parameter int HUM11_CYC = htr_pkg::cyc_of_us(htr_pkg::T_HUM11_US),
	parameter int HUM8_CYC = htr_pkg::cyc_of_us(htr_pkg::T_HUM8_US)
)
(
	input wire logic mclk, // System clock
	input wire logic resetn, // Synchronous reset
	htr_link_if.dev link, // Serial link
	input wire logic [13:0] sense_temp, // Raw temperature sample
	input wire logic [13:0] sense_humid, // Raw humidity sample
	output logic conv_busy // Conversion running
);
	typedef enum {DS_IDLE, DS_ADDR, DS_PTR, DS_WDATA, DS_ACK, DS_TX, DS_RX_ACK} htr_dev_state_type;
	typedef enum {CV_IDLE, CV_TEMP, CV_HUMID} htr_conv_state_type;

	if (TMP14_CYC < 1 || TMP11_CYC < 1 || HUM14_CYC < 1 || HUM11_CYC < 1 || HUM8_CYC < 1)
	begin : bad_cycles
		$error("conversion cycle counts must be at least one");
	end

	// ==========================================
	// Pin synchronisers and bus events
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'h1;
			sda_prev_reg <= 1'h1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	wire logic scl_s = scl_sync_reg[1];
	wire logic sda_s = sda_sync_reg[1];
	wire logic scl_rise = scl_s & ~scl_prev_reg;
	wire logic scl_fall = ~scl_s & scl_prev_reg;
	wire logic start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	wire logic stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	// ==========================================
	// Registers seen through the link
	htr_dev_state_type state_reg;
	htr_dev_state_type ret_reg;
	htr_conv_state_type conv_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic low_reg;
	logic lsb_next_reg;
	logic ack_ok_reg;
	logic wr_lsb_reg;
	logic trig_reg;
	logic mode_reg;
	logic temp_resolution_sel_reg;
	logic [1:0] humid_resolution_sel_reg;
	logic [15:0] temp_reg;
	logic [15:0] humid_reg;
	logic [31:0] conv_cnt_reg;

	wire logic byte_done = scl_fall && bit_cnt_reg == 4'h8;
	wire logic [15:0] cfg_wr = {sh_reg, 8'h00};
	wire logic [15:0] cfg_word = (16'(mode_reg) << htr_pkg::CFG_MODE_POS)
		| (16'(temp_resolution_sel_reg) << htr_pkg::CFG_TEMP_RESOLUTION_SEL_POS) | (16'(humid_resolution_sel_reg) << htr_pkg::CFG_HUMID_RESOLUTION_SEL_POS);
	wire logic [15:0] rd_word = (ptr_reg == htr_pkg::PTR_TEMP) ? temp_reg
		: (ptr_reg == htr_pkg::PTR_HUMID) ? humid_reg
		: (ptr_reg == htr_pkg::PTR_CFG) ? cfg_word : 16'h0000;
	wire logic [7:0] next_tx = lsb_next_reg ? rd_word[7:0] : rd_word[15:8];

	assign conv_busy = conv_reg != CV_IDLE;
	assign link.sda_d_o = 1'h0;
	assign link.sda_d_oe_n = ~low_reg;

	// ==========================================
	// Serial slave
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state_reg <= DS_IDLE;
			ret_reg <= DS_IDLE;
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= htr_pkg::PTR_TEMP;
			low_reg <= 1'h0;
			lsb_next_reg <= 1'h0;
			ack_ok_reg <= 1'h0;
			wr_lsb_reg <= 1'h0;
			trig_reg <= 1'h0;
			mode_reg <= htr_pkg::CFG_MODE_RST;
			temp_resolution_sel_reg <= htr_pkg::CFG_TEMP_RESOLUTION_SEL_RST;
			humid_resolution_sel_reg <= htr_pkg::CFG_HUMID_RESOLUTION_SEL_RST;
		end
		else
		begin
			trig_reg <= 1'h0;
			if (start_det)
			begin
				state_reg <= DS_ADDR;
				bit_cnt_reg <= 4'h0;
				low_reg <= 1'h0;
			end
			else if (stop_det)
			begin
				state_reg <= DS_IDLE;
				low_reg <= 1'h0;
			end
			else
			begin
				unique case (state_reg)
					DS_IDLE:
					begin
					end
					DS_ADDR:
					begin
						if (scl_rise)
						begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (byte_done)
						begin
							bit_cnt_reg <= 4'h0;
							// Unmatched address or busy read: line stays released
							if (sh_reg[7:1] != htr_pkg::DEV_ADDR || (sh_reg[0] && conv_busy))
								state_reg <= DS_IDLE;
							else
							begin
								low_reg <= 1'h1;
								state_reg <= DS_ACK;
								ret_reg <= sh_reg[0] ? DS_TX : DS_PTR;
								tx_reg <= rd_word[15:8];
								lsb_next_reg <= 1'h1;
							end
						end
					end
					DS_PTR:
					begin
						if (scl_rise)
						begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (byte_done)
						begin
							bit_cnt_reg <= 4'h0;
							ptr_reg <= sh_reg;
							trig_reg <= sh_reg <= htr_pkg::PTR_HUMID;
							low_reg <= 1'h1;
							wr_lsb_reg <= 1'h0;
							state_reg <= DS_ACK;
							ret_reg <= DS_WDATA;
						end
					end
					DS_WDATA:
					begin
						if (scl_rise)
						begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (byte_done)
						begin
							bit_cnt_reg <= 4'h0;
							// Only the upper byte carries settings; the lower is reserved
							if (ptr_reg == htr_pkg::PTR_CFG && !wr_lsb_reg)
							begin
								if (cfg_wr[htr_pkg::CFG_RST_POS])
								begin
									mode_reg <= htr_pkg::CFG_MODE_RST;
									temp_resolution_sel_reg <= htr_pkg::CFG_TEMP_RESOLUTION_SEL_RST;
									humid_resolution_sel_reg <= htr_pkg::CFG_HUMID_RESOLUTION_SEL_RST;
								end
								else
								begin
									mode_reg <= cfg_wr[htr_pkg::CFG_MODE_POS];
									temp_resolution_sel_reg <= cfg_wr[htr_pkg::CFG_TEMP_RESOLUTION_SEL_POS];
									humid_resolution_sel_reg <= cfg_wr[htr_pkg::CFG_HUMID_RESOLUTION_SEL_POS +: 2];
								end
							end
							wr_lsb_reg <= 1'h1;
							low_reg <= 1'h1;
							state_reg <= DS_ACK;
							ret_reg <= DS_WDATA;
						end
					end
					DS_ACK:
					begin
						if (scl_fall)
						begin
							state_reg <= ret_reg;
							low_reg <= 1'h0;
							if (ret_reg == DS_TX)
							begin
								low_reg <= ~tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'h0};
								bit_cnt_reg <= 4'h1;
							end
						end
					end
					DS_TX:
					begin
						if (scl_fall)
						begin
							if (bit_cnt_reg == 4'h8)
							begin
								low_reg <= 1'h0;
								bit_cnt_reg <= 4'h0;
								state_reg <= DS_RX_ACK;
							end
							else
							begin
								low_reg <= ~tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'h0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					DS_RX_ACK:
					begin
						if (scl_rise)
							ack_ok_reg <= ~sda_s;
						else if (scl_fall)
						begin
							if (ack_ok_reg)
							begin
								state_reg <= DS_TX;
								low_reg <= ~next_tx[7];
								tx_reg <= {next_tx[6:0], 1'h0};
								bit_cnt_reg <= 4'h1;
								lsb_next_reg <= ~lsb_next_reg;
								if (lsb_next_reg && ptr_reg == htr_pkg::PTR_TEMP)
									ptr_reg <= htr_pkg::PTR_HUMID;
							end
							else
								state_reg <= DS_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================
	// Conversion timing
	wire logic [31:0] temp_load = temp_resolution_sel_reg ? 32'(TMP11_CYC - 1) : 32'(TMP14_CYC - 1);
	wire logic [31:0] humid_load = (humid_resolution_sel_reg == htr_pkg::RES_11) ? 32'(HUM11_CYC - 1)
		: (humid_resolution_sel_reg == htr_pkg::RES_8) ? 32'(HUM8_CYC - 1) : 32'(HUM14_CYC - 1);
	wire logic first_temp = mode_reg || ptr_reg == htr_pkg::PTR_TEMP;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			conv_reg <= CV_IDLE;
			conv_cnt_reg <= 32'h0;
			temp_reg <= 16'h0000;
			humid_reg <= 16'h0000;
		end
		else if (trig_reg)
		begin
			// A new trigger drops any running conversion
			conv_reg <= first_temp ? CV_TEMP : CV_HUMID;
			conv_cnt_reg <= first_temp ? temp_load : humid_load;
		end
		else if (conv_reg != CV_IDLE)
		begin
			if (conv_cnt_reg != 32'h0)
				conv_cnt_reg <= conv_cnt_reg - 32'h1;
			else if (conv_reg == CV_TEMP)
			begin
				temp_reg <= htr_pkg::res_word(sense_temp, {1'h0, temp_resolution_sel_reg});
				conv_reg <= mode_reg ? CV_HUMID : CV_IDLE;
				conv_cnt_reg <= humid_load;
			end
			else
			begin
				humid_reg <= htr_pkg::res_word(sense_humid, humid_resolution_sel_reg);
				conv_reg <= CV_IDLE;
			end
		end
	end
endmodule // htr_sensor

// File: core/htr_pkg.sv
// Shared constants and helpers for the humidity and temperature readout link
package htr_pkg;
	// ==========================================
	// Clock and link rates
	localparam int MCLK_HZ = 25000000;
	localparam int MCLK_MHZ = 25;
	localparam int SCL_HZ = 100000;
	localparam int QTR_CYC = (MCLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
	// ==========================================
	// Sensor address and register pointers
	localparam logic [6:0] DEV_ADDR = 7'h40;
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_HUMID = 8'h01;
	localparam logic [7:0] PTR_CFG = 8'h02;
	// ==========================================
	// Configuration word layout and reset values
	localparam int CFG_RST_POS = 15;
	localparam int CFG_MODE_POS = 12;
	localparam int CFG_TEMP_RESOLUTION_SEL_POS = 10;
	localparam int CFG_HUMID_RESOLUTION_SEL_POS = 8;
	localparam logic CFG_MODE_RST = 1'h1;
	localparam logic CFG_TEMP_RESOLUTION_SEL_RST = 1'h0;
	localparam logic [1:0] CFG_HUMID_RESOLUTION_SEL_RST = 2'h0;
	localparam logic [1:0] RES_14 = 2'h0;
	localparam logic [1:0] RES_11 = 2'h1;
	localparam logic [1:0] RES_8 = 2'h2;
	// ==========================================
	// Times in microseconds
	localparam int T_POWER_US = 15000;
	localparam int T_TMP14_US = 6350;
	localparam int T_TMP11_US = 3650;
	localparam int T_HUM14_US = 6500;
	localparam int T_HUM11_US = 3850;
	localparam int T_HUM8_US = 2500;
	localparam int T_CONV_US = T_TMP14_US + T_HUM14_US;
	localparam int T_HOLD_US = 1000000;
	// ==========================================
	// Result scaling, results kept in hundredths
	localparam int TEMP_SPAN = 165;
	localparam int TEMP_OFFS = 40;
	localparam int RH_SPAN = 100;
	localparam int FIX_SCALE = 100;
	localparam int RAW_BITS = 16;
	// ==========================================
	// Host register map and fields
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_TEMP_RAW = 3'h2;
	localparam logic [2:0] REG_HUMID_RAW = 3'h3;
	localparam logic [2:0] REG_TEMP_C = 3'h4;
	localparam logic [2:0] REG_HUMID_RH = 3'h5;
	localparam int CTRL_START = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_NACK = 2;
	localparam int ST_PWR = 3;

	function automatic int cyc_of_us(input int us);
		return us * MCLK_MHZ;
	endfunction

	// Drops the bits below the chosen resolution
	function automatic logic [15:0] res_word(input logic [13:0] raw, input logic [1:0] res);
		unique case (res)
			RES_11: return {raw[13:3], 5'h00};
			RES_8: return {raw[13:6], 8'h00};
			default: return {raw, 2'h0};
		endcase
	endfunction
endpackage

// File: core/htr_link_if.sv
// Two-wire serial link between the host and the sensor
`timescale 1ns/1ns
interface htr_link_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_h_o;
	logic sda_h_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	wire scl;
	wire sda;

	// Open drain with pull-ups: a line is low only while someone drives a low
	assign scl = scl_oe_n | scl_o;
	assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

	modport host (output scl_o, output scl_oe_n, output sda_h_o, output sda_h_oe_n,
		input scl, input sda);
	modport dev (output sda_d_o, output sda_d_oe_n, input scl, input sda);
endinterface

// File: core/htr_host.sv
// Host end: serial master that triggers and reads a measurement
`timescale 1ns/1ns
module htr_host #(
	parameter int POWER_CYC = htr_pkg::cyc_of_us(htr_pkg::T_POWER_US),
	parameter int CONV_CYC = htr_pkg::cyc_of_us(htr_pkg::T_CONV_US),
	parameter int HOLD_CYC = htr_pkg::cyc_of_us(htr_pkg::T_HOLD_US),
	parameter int QTR_CYC = htr_pkg::QTR_CYC
)
(
	input wire logic mclk, // System clock
	input wire logic resetn, // Synchronous reset
	htr_link_if.host link, // Serial link
	input wire logic [2:0] reg_addr, // Register address
	input wire logic [15:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [15:0] reg_rdata // Read data, cycle after strobe
);
	typedef enum {H_POWER, H_IDLE, H_START, H_BIT, H_STOP, H_CONV, H_HOLD} htr_host_state_type;

	if (POWER_CYC < 1 || CONV_CYC < 1 || HOLD_CYC < 1 || QTR_CYC < 2)
	begin : bad_cycles
		$error("host cycle counts out of range");
	end

	// ==========================================
	// Line sampling and quarter-bit divider
	logic [1:0] sda_sync_reg;
	logic [15:0] qcnt_reg;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sda_sync_reg <= 2'h3;
			qcnt_reg <= 16'h0000;
		end
		else
		begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			qcnt_reg <= (qcnt_reg == 16'(QTR_CYC - 1)) ? 16'h0000 : qcnt_reg + 16'h0001;
		end
	end

	wire logic qt = qcnt_reg == 16'h0000;
	wire logic sda_s = sda_sync_reg[1];

	// ==========================================
	// Sequencer and bit engine
	htr_host_state_type state_reg;
	logic [31:0] wait_reg;
	logic [1:0] ph_reg;
	logic [3:0] bit_cnt_reg;
	logic [2:0] bidx_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [15:0] temp_reg;
	logic [15:0] humid_reg;
	logic scl_rel_reg;
	logic sda_rel_reg;
	logic rd_txn_reg;
	logic nack_seen_reg;
	logic ready_reg;
	logic nack_reg;

	wire logic start_cmd = reg_wr && reg_addr == htr_pkg::REG_CTRL && reg_wdata[htr_pkg::CTRL_START];
	wire logic sending = bidx_reg == 3'h0 || !rd_txn_reg;
	wire logic last_byte = rd_txn_reg ? bidx_reg == 3'h4 : bidx_reg == 3'h1;

	assign link.scl_o = 1'h0;
	assign link.scl_oe_n = scl_rel_reg;
	assign link.sda_h_o = 1'h0;
	assign link.sda_h_oe_n = sda_rel_reg;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state_reg <= H_POWER;
			wait_reg <= 32'(POWER_CYC - 1);
			ph_reg <= 2'h0;
			bit_cnt_reg <= 4'h0;
			bidx_reg <= 3'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			temp_reg <= 16'h0000;
			humid_reg <= 16'h0000;
			scl_rel_reg <= 1'h1;
			sda_rel_reg <= 1'h1;
			rd_txn_reg <= 1'h0;
			nack_seen_reg <= 1'h0;
			ready_reg <= 1'h0;
			nack_reg <= 1'h0;
		end
		else
		begin
			unique case (state_reg)
				H_POWER, H_CONV, H_HOLD:
				begin
					ph_reg <= 2'h0;
					if (wait_reg != 32'h0)
						wait_reg <= wait_reg - 32'h1;
					else
					begin
						state_reg <= (state_reg == H_CONV) ? H_START : H_IDLE;
						rd_txn_reg <= state_reg == H_CONV;
					end
				end
				H_IDLE:
				begin
					ph_reg <= 2'h0;
					if (start_cmd)
					begin
						state_reg <= H_START;
						rd_txn_reg <= 1'h0;
						ready_reg <= 1'h0;
						nack_reg <= 1'h0;
					end
				end
				H_START:
				begin
					if (qt)
					begin
						ph_reg <= ph_reg + 2'h1;
						if (ph_reg == 2'h0)
							sda_rel_reg <= 1'h0;
						if (ph_reg == 2'h1)
							scl_rel_reg <= 1'h0;
						if (ph_reg == 2'h3)
						begin
							state_reg <= H_BIT;
							bidx_reg <= 3'h0;
							bit_cnt_reg <= 4'h0;
							tx_reg <= {htr_pkg::DEV_ADDR, rd_txn_reg};
						end
					end
				end
				H_BIT:
				begin
					if (qt)
					begin
						ph_reg <= ph_reg + 2'h1;
						unique case (ph_reg)
							2'h0:
								if (bit_cnt_reg == 4'h8)
									sda_rel_reg <= sending | last_byte;
								else
									sda_rel_reg <= !sending | tx_reg[7];
							2'h1:
								scl_rel_reg <= 1'h1;
							2'h2:
								if (bit_cnt_reg == 4'h8)
									nack_seen_reg <= sending & sda_s;
								else
									rx_reg <= {rx_reg[6:0], sda_s};
							2'h3:
							begin
								scl_rel_reg <= 1'h0;
								if (bit_cnt_reg != 4'h8)
								begin
									tx_reg <= {tx_reg[6:0], 1'h0};
									bit_cnt_reg <= bit_cnt_reg + 4'h1;
								end
								else
								begin
									bit_cnt_reg <= 4'h0;
									// Most significant byte of each word arrives first
									if (rd_txn_reg && bidx_reg == 3'h1)
										temp_reg[15:8] <= rx_reg;
									if (rd_txn_reg && bidx_reg == 3'h2)
										temp_reg[7:0] <= rx_reg;
									if (rd_txn_reg && bidx_reg == 3'h3)
										humid_reg[15:8] <= rx_reg;
									if (rd_txn_reg && bidx_reg == 3'h4)
										humid_reg[7:0] <= rx_reg;
									if (nack_seen_reg)
									begin
										nack_reg <= 1'h1;
										state_reg <= H_STOP;
									end
									else if (last_byte)
										state_reg <= H_STOP;
									else
									begin
										bidx_reg <= bidx_reg + 3'h1;
										tx_reg <= htr_pkg::PTR_TEMP;
									end
								end
							end
						endcase
					end
				end
				H_STOP:
				begin
					if (qt)
					begin
						ph_reg <= ph_reg + 2'h1;
						if (ph_reg == 2'h0)
							sda_rel_reg <= 1'h0;
						if (ph_reg == 2'h1)
							scl_rel_reg <= 1'h1;
						if (ph_reg == 2'h2)
							sda_rel_reg <= 1'h1;
						if (ph_reg == 2'h3)
						begin
							state_reg <= nack_reg ? H_IDLE : (rd_txn_reg ? H_HOLD : H_CONV);
							wait_reg <= rd_txn_reg ? 32'(HOLD_CYC - 1) : 32'(CONV_CYC - 1);
							ready_reg <= rd_txn_reg & ~nack_reg;
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// Scaled results and register port
	wire logic [31:0] t_prod = 32'(temp_reg) * 32'(htr_pkg::TEMP_SPAN * htr_pkg::FIX_SCALE);
	wire logic [31:0] h_prod = 32'(humid_reg) * 32'(htr_pkg::RH_SPAN * htr_pkg::FIX_SCALE);
	wire logic [15:0] temp_c = t_prod[htr_pkg::RAW_BITS +: 16]
		- 16'(htr_pkg::TEMP_OFFS * htr_pkg::FIX_SCALE);
	wire logic [15:0] humid_rh = h_prod[htr_pkg::RAW_BITS +: 16];
	wire logic [15:0] status_word = (16'(state_reg != H_IDLE) << htr_pkg::ST_BUSY)
		| (16'(ready_reg) << htr_pkg::ST_READY) | (16'(nack_reg) << htr_pkg::ST_NACK)
		| (16'(state_reg != H_POWER) << htr_pkg::ST_PWR);
	wire logic [15:0] rd_mux = (reg_addr == htr_pkg::REG_STATUS) ? status_word
		: (reg_addr == htr_pkg::REG_TEMP_RAW) ? temp_reg
		: (reg_addr == htr_pkg::REG_HUMID_RAW) ? humid_reg
		: (reg_addr == htr_pkg::REG_TEMP_C) ? temp_c
		: (reg_addr == htr_pkg::REG_HUMID_RH) ? humid_rh : 16'h0000;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
	end
endmodule // htr_host

// File: verification/htr_link_assertions.sv
// Checker for the serial link between the host and sensor ends
`timescale 1ns/1ns
module htr_link_assertions #(
	parameter int CONV_CYC = 1000,
	parameter int QTR_CYC = htr_pkg::QTR_CYC
)
(
	input wire logic mclk, // Clock
	input wire logic resetn, // Sync reset
	input wire logic scl_o, // Host scl value
	input wire logic scl_oe_n, // Host scl enable
	input wire logic sda_h_o, // Host sda value
	input wire logic sda_h_oe_n, // Host sda enable
	input wire logic sda_d_o, // Sensor sda value
	input wire logic sda_d_oe_n, // Sensor sda enable
	input wire logic scl, // Wire scl
	input wire logic sda, // Wire sda
	input wire logic conv_busy // Conversion running
);
	// Scl low spans two quarters in a bit, four after a start
	localparam int LOW_MIN = 2 * QTR_CYC;
	localparam int LOW_MAX = 4 * QTR_CYC;
	// Pointer ack may overlap the start of a conversion by one bit
	localparam int ACK_MAX = 5 * QTR_CYC;
	int busy_cnt;

	// ==========================================
	// Busy length counter
	always_ff @(posedge mclk)
	begin
		if (!resetn || !conv_busy)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	// ==========================================
	// Link properties
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	a_reset_released: assert property (disable iff (1'b0)
		!resetn |=> scl_oe_n && sda_h_oe_n && sda_d_oe_n && !conv_busy)
		else $error("lines not released after reset");
	a_drive_low_only: assert property (!scl_o && !sda_h_o && !sda_d_o)
		else $error("open drain value not low");
	a_sensor_data_stable: assert property (
		scl && $past(scl) && $changed(sda) |-> sda_d_oe_n && $past(sda_d_oe_n))
		else $error("sensor moved sda while scl high");
	a_start_by_host: assert property ($fell(sda) && scl |-> !sda_h_oe_n)
		else $error("start not made by host");
	a_scl_low_bound: assert property ($fell(scl) |-> ##[LOW_MIN:LOW_MAX] scl)
		else $error("scl low too long");
	a_trigger_ack: assert property ($rose(conv_busy) |-> ##[0:8] !sda_d_oe_n)
		else $error("trigger without pointer ack");
	a_busy_length: assert property ($fell(conv_busy) |->
		busy_cnt >= CONV_CYC - 4 && busy_cnt <= CONV_CYC + 4)
		else $error("conversion length wrong");
	a_busy_no_ack: assert property (
		conv_busy && busy_cnt > ACK_MAX |-> sda_d_oe_n)
		else $error("sensor drove sda while converting");
	c_conv_done: cover property ($fell(conv_busy));
endmodule // htr_link_assertions

// File: verification/tb_humidity_temp_measure_readout.sv
// Self-checking bench for the host and sensor ends of the readout link
`timescale 1ns/1ns
module tb_humidity_temp_measure_readout;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [13:0] sense_temp = 14'h0000;
	logic [13:0] sense_humid = 14'h0000;
	logic conv_busy;
	logic conv_busy_b;
	logic [15:0] rd_val;
	logic b_low_reg = 1'b0;
	int b_acks = 0;
	int failures = 0;
	int comparisons = 0;

	htr_link_if link();
	htr_link_if link_b();

	always #20 mclk = ~mclk;

	// ==========================================
	// Main pair, and a slow sensor that overhears the same host
	htr_sensor #(.TMP14_CYC(500), .HUM14_CYC(500)) i_htr_sensor (.mclk(mclk),
		.resetn(resetn), .link(link.dev),
		.sense_temp(sense_temp), .sense_humid(sense_humid), .conv_busy(conv_busy));
	htr_host #(.POWER_CYC(200), .CONV_CYC(1200), .HOLD_CYC(300)) i_htr_host (
		.mclk(mclk), .resetn(resetn), .link(link.host), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Full-length conversions: every read reaches it while it is still busy
	htr_sensor i_htr_sensor_b (.mclk(mclk), .resetn(resetn), .link(link_b.dev),
		.sense_temp(sense_temp), .sense_humid(sense_humid), .conv_busy(conv_busy_b));

	assign link_b.scl_o = link.scl_o;
	assign link_b.scl_oe_n = link.scl_oe_n;
	assign link_b.sda_h_o = link.sda_h_o;
	assign link_b.sda_h_oe_n = link.sda_h_oe_n;

	// Low pulses of the slow sensor: write acks only, never read data
	always @(posedge mclk)
	begin
		b_low_reg <= !link_b.sda_d_oe_n;
		if (!link_b.sda_d_oe_n && !b_low_reg)
			b_acks <= b_acks + 1;
	end

	htr_link_assertions i_htr_link_assertions (.mclk(mclk),
		.resetn(resetn), .scl_o(link.scl_o), .scl_oe_n(link.scl_oe_n), .sda_h_o(link.sda_h_o),
		.sda_h_oe_n(link.sda_h_oe_n), .sda_d_o(link.sda_d_o), .sda_d_oe_n(link.sda_d_oe_n),
		.scl(link.scl), .sda(link.sda), .conv_busy(conv_busy));

	// ==========================================
	// Bench tasks and expectations
	task automatic report_and_stop();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Trailing 1 ns keeps a strobe from being set twice in one step
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	task automatic wait_bit(input int pos, input logic val);
		int n;
		n = 0;
		rd(htr_pkg::REG_STATUS);
		while (rd_val[pos] !== val)
		begin
			n++;
			if (n > 30000)
			begin
				failures++;
				$display("[FAIL] %0t status bit %0d stuck", $time, pos);
				report_and_stop();
			end
			rd(htr_pkg::REG_STATUS);
		end
	endtask

	function automatic logic [15:0] exp_status(input logic busy, input logic ready,
		input logic nack, input logic pwr);
		logic [15:0] w;
		w = 16'h0000;
		w[htr_pkg::ST_BUSY] = busy;
		w[htr_pkg::ST_READY] = ready;
		w[htr_pkg::ST_NACK] = nack;
		w[htr_pkg::ST_PWR] = pwr;
		return w;
	endfunction

	function automatic logic [15:0] raw_exp(input logic [13:0] r);
		return {r, 2'h0};
	endfunction

	// ==========================================
	// Sequence
	initial
	begin
		logic [13:0] t;
		logic [13:0] h;
		void'($urandom(32'hD9EA280C));
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rd(htr_pkg::REG_STATUS);
		check("status", rd_val, exp_status(1'b1, 1'b0, 1'b0, 1'b0));
		rd(3'h6);
		check("unmapped", rd_val, 16'h0000);
		// Start during the power wait must be ignored
		wr(htr_pkg::REG_CTRL, 16'h0001);
		rd(htr_pkg::REG_STATUS);
		check("early start", rd_val, exp_status(1'b1, 1'b0, 1'b0, 1'b0));
		wait_bit(htr_pkg::ST_PWR, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			t = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom());
			h = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : 14'($urandom());
			sense_temp <= t;
			sense_humid <= h;
			wr(htr_pkg::REG_CTRL, 16'h0001);
			rd(htr_pkg::REG_STATUS);
			check("busy", {15'h0000, rd_val[htr_pkg::ST_BUSY]}, 16'h0001);
			wait_bit(htr_pkg::ST_BUSY, 1'b0);
			check("done", rd_val, exp_status(1'b0, 1'b1, 1'b0, 1'b1));
			check("early read", 16'(b_acks), 16'(2 * (i + 1)));
			check("busy b", {15'h0000, conv_busy_b}, 16'h0001);
			rd(htr_pkg::REG_TEMP_RAW);
			check("temp raw", rd_val, raw_exp(t));
			rd(htr_pkg::REG_HUMID_RAW);
			check("humid raw", rd_val, raw_exp(h));
			$display("test measure %0d done", i);
		end
		report_and_stop();
	end
endmodule // tb_humidity_temp_measure_readout
